// ---- verilog/tcu_timer_unit.sv ----
// Three timer/counters with run, mode and flag control registers
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module tcu_timer_unit
  import tcu_pkg::*;
#(
  parameter int unsigned MC_CLKS = OSC_PER_MACHINE_CYCLE
) (
  input wire logic clk, // Oscillator clock, 50 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [3:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic first_count_pin, // First timer count input
  input wire logic second_count_pin, // Second timer count input
  input wire logic third_count_pin, // Third timer count input
  input wire logic third_trigger_pin, // Third timer capture/reload trigger
  input wire logic ext_irq_a_pin, // External interrupt A, gate 0
  input wire logic ext_irq_b_pin, // External interrupt B, gate 1
  input wire tcu_ack_t irq_ack, // Vector acknowledge pulses
  output tcu_flags_t irq_flags, // Interrupt request flags
  output logic second_timer_overflow_pulse, // Baud source pulse
  output logic third_timer_overflow_pulse, // Baud source pulse
  output logic third_timer_baud_mode // Third timer clocks a uart
);

  if (MC_CLKS < 2 || MC_CLKS > 16) begin : g_check
    $error("MC_CLKS must lie in 2..16");
  end

  localparam logic [3:0] MC_LAST = 4'(MC_CLKS - 1);
  localparam int MC_GAP = int'(MC_CLKS) - 1;

  tcu_state_t q;
  tcu_state_t d;
  logic [NUM_PINS-1:0] pins;
  logic [NUM_PINS-1:0] lvl;
  logic [NUM_PINS-1:0] pend;
  logic tick;
  logic split;
  logic en0;
  logic en1;
  logic inc0;
  logic inc0h;
  logic inc1;
  logic inc2;
  logic trig2;
  logic brg;
  logic set_tf0;
  logic set_tf1;
  logic set_tf2;
  logic set_third_trigger_flag;
  logic set_ie0;
  logic set_ie1;
  logic wr_ctrl;
  logic wr_t2ctrl;
  logic [15:0] cnt2;
  logic [15:0] cap2;
  tcu_step_t st0;
  tcu_step_t st1;
  tcu_ctrl_t ctrl_base;
  tcu_t2ctrl_t t2_base;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and machine-cycle samplers
  assign pins = {ext_irq_b_pin, ext_irq_a_pin, third_trigger_pin,
                 third_count_pin, second_count_pin, first_count_pin};

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    tcu_pin_sampler u_smp (
      .clk(clk),
      .resetn(resetn),
      .tick(tick),
      .pin(pins[i]),
      .level(lvl[i]),
      .fall_pend(pend[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // One counting step of timer zero or one
  function automatic tcu_step_t step(tcu_mode_t m, logic [7:0] lo, logic [7:0] hi);
    tcu_step_t r;
    logic [12:0] c13;
    logic [15:0] c16;
    r = '{ovf: 1'b0, hi: hi, lo: lo};
    c13 = {hi, lo[4:0]} + 13'h1;
    c16 = {hi, lo} + 16'h1;
    case (m)
      MODE_13BIT: begin
        r.hi = c13[12:5];
        r.lo = {lo[7:5], c13[4:0]};
        r.ovf = &{hi, lo[4:0]};
      end
      MODE_16BIT: begin
        {r.hi, r.lo} = c16;
        r.ovf = &{hi, lo};
      end
      MODE_RELOAD8: begin
        r.lo = (&lo) ? hi : lo + 8'h1;
        r.ovf = &lo;
      end
      default: begin
        r.lo = lo + 8'h1;
        r.ovf = &lo;
      end
    endcase
    return r;
  endfunction : step

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    d.t1_ovf_pulse = 1'b0;
    d.t2_ovf_pulse = 1'b0;
    tick = (q.presc == MC_LAST);
    d.presc = tick ? 4'h0 : q.presc + 4'h1;
    wr_ctrl = reg_wr && (reg_addr == ADDR_TIMER_RUN_AND_FLAG_CONTROL);
    wr_t2ctrl = reg_wr && (reg_addr == ADDR_THIRD_TIMER_CONTROL);
    split = (q.tmode.first.mode == MODE_SPLIT);
    set_tf0 = 1'b0;
    set_tf1 = 1'b0;
    set_tf2 = 1'b0;
    set_third_trigger_flag = 1'b0;

    // Timer zero, low byte alone when split
    en0 = q.ctrl.first_timer_run && (!q.tmode.first.gate || lvl[PIN_EXT_IRQ_A]);
    inc0 = tick && en0 && (q.tmode.first.count_select ? pend[PIN_FIRST_COUNT] : 1'b1);
    st0 = step(q.tmode.first.mode, q.first_timer_low_byte, q.first_timer_high_byte);
    if (inc0) begin
      d.first_timer_low_byte = st0.lo;
      if (!split) begin
        d.first_timer_high_byte = st0.hi;
      end
      set_tf0 = st0.ovf;
    end

    // Split high byte of timer zero borrows second run bit and flag
    inc0h = tick && split && q.ctrl.second_timer_run;
    if (inc0h) begin
      d.first_timer_high_byte = q.first_timer_high_byte + 8'h1;
      set_tf1 = &q.first_timer_high_byte;
    end

    // Timer one; runs on its own mode while timer zero is split
    en1 = (split ? 1'b1 : q.ctrl.second_timer_run)
          && (!q.tmode.second.gate || lvl[PIN_EXT_IRQ_B])
          && (q.tmode.second.mode != MODE_SPLIT);
    inc1 = tick && en1 && (q.tmode.second.count_select ? pend[PIN_SECOND_COUNT] : 1'b1);
    st1 = step(q.tmode.second.mode, q.second_timer_low_byte, q.second_timer_high_byte);
    if (inc1) begin
      d.second_timer_low_byte = st1.lo;
      d.second_timer_high_byte = st1.hi;
      d.t1_ovf_pulse = st1.ovf;
      if (!split) begin
        set_tf1 = st1.ovf;
      end
    end

    // Timer two
    brg = q.t2ctrl.uart_a_rx_clock_select || q.t2ctrl.uart_a_tx_clock_select
          || q.uart_b_rx_clock_select || q.uart_b_tx_clock_select;
    cnt2 = {q.third_timer_high_byte, q.third_timer_low_byte};
    cap2 = {q.capture_reload_high, q.capture_reload_low};
    inc2 = tick && q.t2ctrl.third_timer_run
           && (q.t2ctrl.third_count_source_select ? pend[PIN_THIRD_COUNT] : 1'b1);
    trig2 = tick && q.t2ctrl.third_trigger_enable && pend[PIN_THIRD_TRIGGER];
    if (inc2) begin
      if (&cnt2) begin
        d.t2_ovf_pulse = 1'b1;
        set_tf2 = !brg;
        if (q.t2ctrl.capture_or_reload_select && !brg) begin
          {d.third_timer_high_byte, d.third_timer_low_byte} = 16'h0000;
        end else begin
          {d.third_timer_high_byte, d.third_timer_low_byte} = cap2;
        end
      end else begin
        {d.third_timer_high_byte, d.third_timer_low_byte} = cnt2 + 16'h1;
      end
    end
    if (trig2) begin
      set_third_trigger_flag = 1'b1;
      if (!brg) begin
        if (q.t2ctrl.capture_or_reload_select) begin
          {d.capture_reload_high, d.capture_reload_low} = cnt2;
        end else begin
          {d.third_timer_high_byte, d.third_timer_low_byte} = cap2;
        end
      end
    end

    // External interrupt flags
    set_ie0 = q.ctrl.ext_irq_a_trigger_type ? (tick && pend[PIN_EXT_IRQ_A])
                                            : !lvl[PIN_EXT_IRQ_A];
    set_ie1 = q.ctrl.ext_irq_b_trigger_type ? (tick && pend[PIN_EXT_IRQ_B])
                                            : !lvl[PIN_EXT_IRQ_B];

    // Software writes override counting in the same cycle
    if (reg_wr) begin
      case (reg_addr)
        ADDR_TIMER_MODE_SELECT: d.tmode = tcu_tmode_t'(reg_wdata);
        ADDR_FIRST_TIMER_LOW_BYTE: d.first_timer_low_byte = reg_wdata;
        ADDR_FIRST_TIMER_HIGH_BYTE: d.first_timer_high_byte = reg_wdata;
        ADDR_SECOND_TIMER_LOW_BYTE: d.second_timer_low_byte = reg_wdata;
        ADDR_SECOND_TIMER_HIGH_BYTE: d.second_timer_high_byte = reg_wdata;
        ADDR_THIRD_TIMER_LOW_BYTE: d.third_timer_low_byte = reg_wdata;
        ADDR_THIRD_TIMER_HIGH_BYTE: d.third_timer_high_byte = reg_wdata;
        ADDR_CAPTURE_RELOAD_LOW: d.capture_reload_low = reg_wdata;
        ADDR_CAPTURE_RELOAD_HIGH: d.capture_reload_high = reg_wdata;
        ADDR_UART_B_CLOCK_SELECT: begin
          d.uart_b_rx_clock_select = reg_wdata[1];
          d.uart_b_tx_clock_select = reg_wdata[0];
        end
        default: begin
        end
      endcase
    end

    // Control registers; counts are never touched here
    ctrl_base = wr_ctrl ? tcu_ctrl_t'(reg_wdata) : q.ctrl;
    d.ctrl = ctrl_base;
    d.ctrl.first_timer_overflow_flag = set_tf0 ||
      (ctrl_base.first_timer_overflow_flag && !irq_ack.first_timer);
    d.ctrl.second_timer_overflow_flag = set_tf1 ||
      (ctrl_base.second_timer_overflow_flag && !irq_ack.second_timer);
    d.ctrl.ext_irq_a_edge_flag = set_ie0 ||
      (ctrl_base.ext_irq_a_edge_flag && !irq_ack.ext_irq_a);
    d.ctrl.ext_irq_b_edge_flag = set_ie1 ||
      (ctrl_base.ext_irq_b_edge_flag && !irq_ack.ext_irq_b);
    t2_base = wr_t2ctrl ? tcu_t2ctrl_t'(reg_wdata) : q.t2ctrl;
    d.t2ctrl = t2_base;
    d.t2ctrl.third_timer_overflow_flag = set_tf2 || t2_base.third_timer_overflow_flag;
    d.t2ctrl.third_trigger_flag = set_third_trigger_flag || t2_base.third_trigger_flag;

    // Read data stands for one cycle only
    d.rdata = RST_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_TIMER_RUN_AND_FLAG_CONTROL: d.rdata = q.ctrl;
        ADDR_TIMER_MODE_SELECT: d.rdata = q.tmode;
        ADDR_FIRST_TIMER_LOW_BYTE: d.rdata = q.first_timer_low_byte;
        ADDR_FIRST_TIMER_HIGH_BYTE: d.rdata = q.first_timer_high_byte;
        ADDR_SECOND_TIMER_LOW_BYTE: d.rdata = q.second_timer_low_byte;
        ADDR_SECOND_TIMER_HIGH_BYTE: d.rdata = q.second_timer_high_byte;
        ADDR_THIRD_TIMER_CONTROL: d.rdata = q.t2ctrl;
        ADDR_THIRD_TIMER_LOW_BYTE: d.rdata = q.third_timer_low_byte;
        ADDR_THIRD_TIMER_HIGH_BYTE: d.rdata = q.third_timer_high_byte;
        ADDR_CAPTURE_RELOAD_LOW: d.rdata = q.capture_reload_low;
        ADDR_CAPTURE_RELOAD_HIGH: d.rdata = q.capture_reload_high;
        ADDR_UART_B_CLOCK_SELECT: d.rdata = {6'h00, q.uart_b_rx_clock_select,
                                             q.uart_b_tx_clock_select};
        default: d.rdata = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = q.rdata;
  assign irq_flags = '{
    first_timer_overflow_flag: q.ctrl.first_timer_overflow_flag,
    second_timer_overflow_flag: q.ctrl.second_timer_overflow_flag,
    ext_irq_a_edge_flag: q.ctrl.ext_irq_a_edge_flag,
    ext_irq_b_edge_flag: q.ctrl.ext_irq_b_edge_flag,
    third_timer_overflow_flag: q.t2ctrl.third_timer_overflow_flag,
    third_trigger_flag: q.t2ctrl.third_trigger_flag
  };
  assign second_timer_overflow_pulse = q.t1_ovf_pulse;
  assign third_timer_overflow_pulse = q.t2_ovf_pulse;
  assign third_timer_baud_mode = brg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_tick_period;
    @(posedge clk) disable iff (!resetn)
    tick |=> !tick ##MC_GAP tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick period wrong");

  property p_count16;
    @(posedge clk) disable iff (!resetn)
    (inc0 && q.tmode.first.mode == MODE_16BIT && !reg_wr)
      |=> {q.first_timer_high_byte, q.first_timer_low_byte} ==
          $past({q.first_timer_high_byte, q.first_timer_low_byte}) + 16'h1;
  endproperty
  a_count16: assert property (p_count16) else $error("16-bit step wrong");

  property p_reload8;
    @(posedge clk) disable iff (!resetn)
    (inc0 && q.tmode.first.mode == MODE_RELOAD8 && &q.first_timer_low_byte && !reg_wr)
      |=> q.first_timer_low_byte == $past(q.first_timer_high_byte)
          && q.ctrl.first_timer_overflow_flag;
  endproperty
  a_reload8: assert property (p_reload8) else $error("8-bit reload wrong");

  property p_ack_clear;
    @(posedge clk) disable iff (!resetn)
    (irq_ack.first_timer && !set_tf0 && !wr_ctrl) |=> !q.ctrl.first_timer_overflow_flag;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack did not clear");

  property p_baud_no_flag;
    @(posedge clk) disable iff (!resetn)
    (brg && !wr_t2ctrl && !q.t2ctrl.third_timer_overflow_flag)
      |=> !q.t2ctrl.third_timer_overflow_flag;
  endproperty
  a_baud_no_flag: assert property (p_baud_no_flag) else $error("flag set in baud");

  property p_write_wins;
    @(posedge clk) disable iff (!resetn)
    (reg_wr && reg_addr == ADDR_FIRST_TIMER_LOW_BYTE)
      |=> q.first_timer_low_byte == $past(reg_wdata);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("write lost");

  property p_t2_stopped;
    @(posedge clk) disable iff (!resetn)
    (!q.t2ctrl.third_timer_run && !trig2 && !reg_wr) |=> $stable(cnt2);
  endproperty
  a_t2_stopped: assert property (p_t2_stopped) else $error("stopped timer moved");

  property p_capture;
    @(posedge clk) disable iff (!resetn)
    (trig2 && q.t2ctrl.capture_or_reload_select && !brg && !reg_wr)
      |=> cap2 == $past(cnt2) && q.t2ctrl.third_trigger_flag;
  endproperty
  a_capture: assert property (p_capture) else $error("capture wrong");

  property p_t1_hold;
    @(posedge clk) disable iff (!resetn)
    (q.tmode.second.mode == MODE_SPLIT && !reg_wr) |=> $stable(q.second_timer_low_byte)
      && $stable(q.second_timer_high_byte);
  endproperty
  a_t1_hold: assert property (p_t1_hold) else $error("held timer moved");

endmodule : tcu_timer_unit

// ---- verilog/tcu_pkg.sv ----
// Package of types and constants for the triple timer/counter unit
package tcu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned OSC_PER_MACHINE_CYCLE = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [3:0] ADDR_TIMER_RUN_AND_FLAG_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_TIMER_MODE_SELECT = 4'h1;
  localparam logic [3:0] ADDR_FIRST_TIMER_LOW_BYTE = 4'h2;
  localparam logic [3:0] ADDR_FIRST_TIMER_HIGH_BYTE = 4'h3;
  localparam logic [3:0] ADDR_SECOND_TIMER_LOW_BYTE = 4'h4;
  localparam logic [3:0] ADDR_SECOND_TIMER_HIGH_BYTE = 4'h5;
  localparam logic [3:0] ADDR_THIRD_TIMER_CONTROL = 4'h6;
  localparam logic [3:0] ADDR_THIRD_TIMER_LOW_BYTE = 4'h7;
  localparam logic [3:0] ADDR_THIRD_TIMER_HIGH_BYTE = 4'h8;
  localparam logic [3:0] ADDR_CAPTURE_RELOAD_LOW = 4'h9;
  localparam logic [3:0] ADDR_CAPTURE_RELOAD_HIGH = 4'ha;
  localparam logic [3:0] ADDR_UART_B_CLOCK_SELECT = 4'hb;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Pin indices into the sampled pin vector
  localparam int unsigned PIN_FIRST_COUNT = 0;
  localparam int unsigned PIN_SECOND_COUNT = 1;
  localparam int unsigned PIN_THIRD_COUNT = 2;
  localparam int unsigned PIN_THIRD_TRIGGER = 3;
  localparam int unsigned PIN_EXT_IRQ_A = 4;
  localparam int unsigned PIN_EXT_IRQ_B = 5;
  localparam int unsigned NUM_PINS = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT
  } tcu_mode_t;

  typedef struct packed {
    logic second_timer_overflow_flag;
    logic second_timer_run;
    logic first_timer_overflow_flag;
    logic first_timer_run;
    logic ext_irq_b_edge_flag;
    logic ext_irq_b_trigger_type;
    logic ext_irq_a_edge_flag;
    logic ext_irq_a_trigger_type;
  } tcu_ctrl_t;

  typedef struct packed {
    logic gate;
    logic count_select;
    tcu_mode_t mode;
  } tcu_nibble_t;

  typedef struct packed {
    tcu_nibble_t second;
    tcu_nibble_t first;
  } tcu_tmode_t;

  typedef struct packed {
    logic third_timer_overflow_flag;
    logic third_trigger_flag;
    logic uart_a_rx_clock_select;
    logic uart_a_tx_clock_select;
    logic third_trigger_enable;
    logic third_timer_run;
    logic third_count_source_select;
    logic capture_or_reload_select;
  } tcu_t2ctrl_t;

  typedef struct packed {
    logic first_timer;
    logic second_timer;
    logic ext_irq_a;
    logic ext_irq_b;
  } tcu_ack_t;

  typedef struct packed {
    logic first_timer_overflow_flag;
    logic second_timer_overflow_flag;
    logic ext_irq_a_edge_flag;
    logic ext_irq_b_edge_flag;
    logic third_timer_overflow_flag;
    logic third_trigger_flag;
  } tcu_flags_t;

  typedef struct packed {
    logic ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } tcu_step_t;

  typedef struct packed {
    logic [1:0] sync;
    logic prev;
    logic pend;
  } tcu_smp_state_t;

  // Sampler after reset: pins idle high, so no false low level or edge
  localparam tcu_smp_state_t SMP_RST = '{sync: 2'b11, prev: 1'b0, pend: 1'b0};

  typedef struct packed {
    logic [3:0] presc;
    tcu_ctrl_t ctrl;
    tcu_tmode_t tmode;
    logic [7:0] first_timer_low_byte;
    logic [7:0] first_timer_high_byte;
    logic [7:0] second_timer_low_byte;
    logic [7:0] second_timer_high_byte;
    tcu_t2ctrl_t t2ctrl;
    logic [7:0] third_timer_low_byte;
    logic [7:0] third_timer_high_byte;
    logic [7:0] capture_reload_low;
    logic [7:0] capture_reload_high;
    logic uart_b_rx_clock_select;
    logic uart_b_tx_clock_select;
    logic [7:0] rdata;
    logic t1_ovf_pulse;
    logic t2_ovf_pulse;
  } tcu_state_t;

endpackage : tcu_pkg

// ---- verilog/tcu_pin_sampler.sv ----
// Pin synchroniser with once-per-machine-cycle falling edge detection
`timescale 1ns/100ps
module tcu_pin_sampler
  import tcu_pkg::*;
(
  input wire logic clk, // Oscillator clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic tick, // Last clock of a machine cycle
  input wire logic pin, // Raw pin
  output logic level, // Synchronised level
  output logic fall_pend // Fall seen, act at next tick
);

  tcu_smp_state_t s_q;
  tcu_smp_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.sync = {s_q.sync[0], pin};
    if (tick) begin
      s_d.prev = s_q.sync[1];
      s_d.pend = s_q.prev & ~s_q.sync[1];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= SMP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.sync[1];
  assign fall_pend = s_q.pend;

endmodule : tcu_pin_sampler

// ---- test/tcu_pin_model.sv ----
// External pin model: count, gate and trigger inputs of the timer unit
`timescale 1ns/100ps
module tcu_pin_model
  import tcu_pkg::*;
#(
  parameter int HOLD = 8
) (
  input wire logic clk, // Oscillator clock
  output logic [NUM_PINS-1:0] pins // Pin levels, idle high
);
  ////////////////////////////////////////
  // Port pins are pulled up between events
  initial pins = '1;
  task automatic lvl(input int idx, input logic val);
    @(posedge clk);
    pins[idx] <= val;
  endtask : lvl
  task automatic fall(input int idx);
    lvl(idx, 1'b0);
    repeat (HOLD) @(posedge clk);
    lvl(idx, 1'b1);
    repeat (HOLD) @(posedge clk);
  endtask : fall
endmodule : tcu_pin_model

// ---- test/tcu_timer_unit_tb.sv ----
// Self-checking bench for the triple timer/counter unit
`timescale 1ns/100ps
module tcu_timer_unit_tb
  import tcu_pkg::*;
;
  localparam int MC = 4;
  localparam logic [3:0] A_CTL = ADDR_TIMER_RUN_AND_FLAG_CONTROL;
  localparam logic [3:0] A_MOD = ADDR_TIMER_MODE_SELECT;
  localparam logic [3:0] A_L0 = ADDR_FIRST_TIMER_LOW_BYTE;
  localparam logic [3:0] A_H0 = ADDR_FIRST_TIMER_HIGH_BYTE;
  localparam logic [3:0] A_L1 = ADDR_SECOND_TIMER_LOW_BYTE;
  localparam logic [3:0] A_H1 = ADDR_SECOND_TIMER_HIGH_BYTE;
  localparam logic [3:0] A_C2 = ADDR_THIRD_TIMER_CONTROL;
  localparam logic [3:0] A_L2 = ADDR_THIRD_TIMER_LOW_BYTE;
  localparam logic [3:0] A_H2 = ADDR_THIRD_TIMER_HIGH_BYTE;
  localparam logic [3:0] A_RL = ADDR_CAPTURE_RELOAD_LOW;
  localparam logic [3:0] A_RH = ADDR_CAPTURE_RELOAD_HIGH;
  logic clk, resetn, reg_wr, reg_rd, t1p, t2p, baud;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, v0;
  logic [NUM_PINS-1:0] pins;
  tcu_ack_t irq_ack;
  tcu_flags_t irq_flags;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int n_t1p = 0;
  int n_t2p = 0;

  tcu_pin_model #(.HOLD(2 * MC)) pm (.clk(clk), .pins(pins));
  tcu_timer_unit #(.MC_CLKS(MC)) uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .first_count_pin(pins[PIN_FIRST_COUNT]), .second_count_pin(pins[PIN_SECOND_COUNT]),
    .third_count_pin(pins[PIN_THIRD_COUNT]), .third_trigger_pin(pins[PIN_THIRD_TRIGGER]),
    .ext_irq_a_pin(pins[PIN_EXT_IRQ_A]), .ext_irq_b_pin(pins[PIN_EXT_IRQ_B]),
    .irq_ack(irq_ack), .irq_flags(irq_flags), .second_timer_overflow_pulse(t1p),
    .third_timer_overflow_pulse(t2p), .third_timer_baud_mode(baud));

  ////////////////////////////////////////
  // Bus, check and report tasks
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic rst();
    @(posedge clk);
    resetn <= 1'b0;
    wt(4);
    resetn <= 1'b1;
  endtask : rst
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk(v, e);
  endtask : rc
  task automatic ack(input logic [3:0] a);
    @(posedge clk);
    irq_ack <= tcu_ack_t'(a);
    @(posedge clk);
    irq_ack <= '0;
  endtask : ack
  task automatic cb(input logic e);
    #1 chk({7'h0, baud}, {7'h0, e});
  endtask : cb
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask : tdone
  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////
  // Clock, timeout and test sequence
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    n_t1p += int'(t1p === 1'b1);
    n_t2p += int'(t2p === 1'b1);
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    irq_ack = '0;
    wt(4);
    resetn <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rc(a[3:0], 8'h00);
    end
    wr(A_MOD, 8'hc6);
    rc(A_MOD, 8'hc6);
    tdone("reset");
    rst();
    wr(A_L0, 8'h10);
    wr(A_MOD, 8'h01);
    wr(A_CTL, 8'h10);
    rd(A_L0);
    v0 = v;
    chk(v0 & 8'hfe, 8'h10);
    wt(3 * MC - 2);
    rc(A_L0, v0 + 8'h03);
    wr(A_CTL, 8'h00);
    rd(A_L0);
    v0 = v;
    wt(3 * MC);
    rc(A_L0, v0);
    wr(A_L0, 8'hff);
    wr(A_CTL, 8'h10);
    wt(2 * MC);
    rc(A_H0, 8'h01);
    rc(A_CTL, 8'h10);
    wr(A_H0, 8'hff);
    wr(A_L0, 8'hff);
    wt(2 * MC);
    rc(A_CTL, 8'h30);
    chk({2'b00, irq_flags}, 8'h20);
    ack(4'b1000);
    rc(A_CTL, 8'h10);
    tdone("mode 1");
    rst();
    wr(A_L1, 8'h1f);
    wr(A_CTL, 8'h40);
    wt(2 * MC);
    rc(A_H1, 8'h01);
    wr(A_H1, 8'hff);
    wr(A_L1, 8'h1f);
    wt(2 * MC);
    rc(A_CTL, 8'hc0);
    rc(A_H1, 8'h00);
    tdone("mode 0");
    rst();
    wr(A_H0, 8'ha0);
    wr(A_L0, 8'hff);
    wr(A_MOD, 8'h02);
    wr(A_CTL, 8'h10);
    wt(2 * MC);
    rc(A_CTL, 8'h30);
    rc(A_H0, 8'ha0);
    rd(A_L0);
    chk(v & 8'hf8, 8'ha0);
    tdone("mode 2");
    rst();
    wr(A_L1, 8'h55);
    wr(A_L0, 8'hfe);
    wr(A_H0, 8'hfe);
    wr(A_MOD, 8'h33);
    wr(A_CTL, 8'h50);
    wt(3 * MC);
    rc(A_CTL, 8'hf0);
    rc(A_L1, 8'h55);
    rst();
    wr(A_H1, 8'hff);
    wr(A_L1, 8'hff);
    wr(A_MOD, 8'h13);
    wt(3 * MC);
    rc(A_CTL, 8'h00);
    rc(A_H1, 8'h00);
    wr(A_MOD, 8'h33);
    rd(A_L1);
    v0 = v;
    wt(3 * MC);
    rc(A_L1, v0);
    chk(8'(n_t1p), 8'h02);
    tdone("mode 3");
    rst();
    pm.lvl(PIN_EXT_IRQ_A, 1'b0);
    wr(A_MOD, 8'h09);
    wr(A_CTL, 8'h10);
    wt(3 * MC);
    rc(A_L0, 8'h00);
    pm.lvl(PIN_EXT_IRQ_A, 1'b1);
    wt(3 * MC);
    rd(A_L0);
    chk(8'(v != 8'h00), 8'h01);
    rst();
    wr(A_MOD, 8'h05);
    wr(A_CTL, 8'h10);
    repeat (3) pm.fall(PIN_FIRST_COUNT);
    wt(2 * MC);
    rc(A_L0, 8'h03);
    tdone("gate and counter");
    rst();
    wr(A_CTL, 8'h04);
    pm.fall(PIN_EXT_IRQ_B);
    rc(A_CTL, 8'h0c);
    chk({2'b00, irq_flags}, 8'h04);
    ack(4'b0001);
    rc(A_CTL, 8'h04);
    pm.lvl(PIN_EXT_IRQ_A, 1'b0);
    wt(2 * MC);
    rc(A_CTL, 8'h06);
    pm.lvl(PIN_EXT_IRQ_A, 1'b1);
    wt(2 * MC);
    ack(4'b0010);
    rc(A_CTL, 8'h04);
    tdone("external irq");
    rst();
    wr(A_L2, 8'h34);
    wr(A_H2, 8'h12);
    wr(A_C2, 8'h09);
    pm.fall(PIN_THIRD_TRIGGER);
    rc(A_RL, 8'h34);
    rc(A_RH, 8'h12);
    rc(A_C2, 8'h49);
    wr(A_C2, 8'h05);
    wr(A_H2, 8'hff);
    wr(A_L2, 8'hff);
    wt(2 * MC);
    rc(A_C2, 8'h85);
    chk({2'b00, irq_flags}, 8'h02);
    rc(A_H2, 8'h00);
    wr(A_C2, 8'h01);
    rc(A_C2, 8'h01);
    rd(A_L2);
    v0 = v;
    wt(3 * MC);
    rc(A_L2, v0);
    wr(A_C2, 8'h06);
    repeat (2) pm.fall(PIN_THIRD_COUNT);
    wt(2 * MC);
    rc(A_L2, v0 + 8'h02);
    tdone("capture");
    rst();
    wr(A_RL, 8'h34);
    wr(A_RH, 8'h12);
    wr(A_H2, 8'hff);
    wr(A_L2, 8'hff);
    wr(A_C2, 8'h04);
    wt(2 * MC);
    rc(A_H2, 8'h12);
    rc(A_C2, 8'h84);
    wr(A_C2, 8'h08);
    wr(A_L2, 8'h00);
    wr(A_H2, 8'h00);
    pm.fall(PIN_THIRD_TRIGGER);
    rc(A_L2, 8'h34);
    rc(A_H2, 8'h12);
    rc(A_C2, 8'h48);
    wr(A_C2, 8'h15);
    cb(1'b1);
    wr(A_H2, 8'hff);
    wr(A_L2, 8'hff);
    wt(2 * MC);
    rc(A_C2, 8'h15);
    rc(A_H2, 8'h12);
    for (int i = 0; i < 2; i++) begin
      wr(A_C2, 8'h20 >> i);
      cb(1'b1);
      wr(A_C2, 8'h00);
      cb(1'b0);
      wr(ADDR_UART_B_CLOCK_SELECT, 8'h01 << i);
      cb(1'b1);
      wr(ADDR_UART_B_CLOCK_SELECT, 8'h00);
    end
    chk(8'(n_t2p), 8'h03);
    tdone("reload and baud");
    results();
  end
endmodule : tcu_timer_unit_tb
